// ===== rtl/rx_link_param_regs.svh
// Register indices, field masks and framing counts for the lane 0
// link parameter capture bank.
// Assumes the includer works in 32-bit AXI4-Lite words (byte = 4 * index).
`ifndef RX_LINK_PARAM_REGS_SVH
`define RX_LINK_PARAM_REGS_SVH

`define RLPC_IDX_LANE_ID     11'h402
`define RLPC_IDX_SCR_LANES   11'h403
`define RLPC_IDX_OCTETS      11'h404
`define RLPC_IDX_FRAMES      11'h405
`define RLPC_IDX_CONVERTERS  11'h406
`define RLPC_IDX_CTRL_RES    11'h407
`define RLPC_IDX_SUBCLASS    11'h408
`define RLPC_NUM_REGS        7

`define RLPC_MASK_LANE_ID    8'h7f
`define RLPC_MASK_SCR_LANES  8'h9f
`define RLPC_MASK_OCTETS     8'hff
`define RLPC_MASK_FRAMES     8'h1f
`define RLPC_MASK_CONVERTERS 8'hff
`define RLPC_MASK_CTRL_RES   8'hdf
`define RLPC_MASK_SUBCLASS   8'hff

`define RLPC_RESET_FIELD     8'h00
`define RLPC_CFG_LEN         4'hd
`define RLPC_CAP_FIRST       4'h2

`endif

// ===== rtl/rx_param_pkg.sv
// Types shared by the lane 0 link parameter capture bank.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package rx_param_pkg;
    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_e;

    typedef enum logic [0:0] {
        CFG_IDLE    = 1'b0,
        CFG_COLLECT = 1'b1
    } cfg_state_e;
endpackage
`default_nettype wire

// ===== rtl/ro_field_reg.sv
// One read-only status byte loaded from captured link data.
// Assumes i_load is a one-cycle pulse on the same clock.
`default_nettype none
`include "rx_link_param_regs.svh"
module ro_field_reg #(
    parameter logic [7:0] MASK = 8'hff
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rstn,
    input  wire logic       i_load,
    input  wire logic [7:0] i_data,
    output logic      [7:0] o_value
);
    // Reserved bits are masked so they always read zero
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            o_value <= `RLPC_RESET_FIELD;
        else if (i_load)
            o_value <= i_data & MASK;
    end
endmodule
`default_nettype wire

// ===== rtl/ila_cfg_parser.sv
// Collects the lane 0 configuration octets and checks their checksum.
// Assumes i_start marks octet 0 and i_valid qualifies every octet.
`default_nettype none
`include "rx_link_param_regs.svh"
module ila_cfg_parser #(
    parameter int CAP_NUM = 7
) (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rstn,
    input  wire logic                 i_start,
    input  wire logic                 i_valid,
    input  wire logic [7:0]           i_octet,
    output logic                      o_load,
    output logic      [CAP_NUM*8-1:0] o_bytes
);
    import rx_param_pkg::*;

    cfg_state_e state_r;
    logic [3:0] idx_r;
    logic [7:0] sum_r;
    logic [3:0] slot;

    assign slot = idx_r - `RLPC_CAP_FIRST;

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_r <= CFG_IDLE;
            idx_r   <= 4'h0;
            sum_r   <= 8'h00;
            o_load  <= 1'b0;
        end
        else
        begin
            o_load <= 1'b0;
            if (i_valid && i_start)
            begin
                state_r <= CFG_COLLECT;
                idx_r   <= 4'h1;
                sum_r   <= i_octet;
            end
            else if (i_valid && state_r == CFG_COLLECT)
            begin
                if (idx_r == `RLPC_CFG_LEN)
                begin
                    // Last octet is the checksum of all earlier ones
                    state_r <= CFG_IDLE;
                    o_load  <= (sum_r == i_octet);
                end
                else
                begin
                    idx_r <= idx_r + 4'h1;
                    sum_r <= sum_r + i_octet;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            o_bytes <= '0;
        else if (i_valid && !i_start && state_r == CFG_COLLECT &&
                 idx_r >= `RLPC_CAP_FIRST && slot < 4'(CAP_NUM))
            o_bytes[slot*8 +: 8] <= i_octet;
    end
endmodule
`default_nettype wire

// ===== rtl/rx_link_param_capture.sv
// Lane 0 link parameter capture bank with an AXI4-Lite read port.
// Assumes the lane 0 octet stream arrives on i_clk_sys from the
// receiver's alignment logic; no synchronisers are needed on it.
//
// The AXI4-Lite slave port was decided locally.
`default_nettype none
`include "rx_link_param_regs.svh"
module rx_link_param_capture #(
    parameter int ADDR_W = 13
) (
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rstn,
    input  wire logic                    i_ila_start,
    input  wire logic                    i_ila_valid,
    input  wire logic [7:0]              i_ila_octet,
    input  wire logic [ADDR_W-1:0]       i_s_axi_awaddr,
    input  wire logic                    i_s_axi_awvalid,
    output logic                         o_s_axi_awready,
    input  wire logic [31:0]             i_s_axi_wdata,
    input  wire logic [3:0]              i_s_axi_wstrb,
    input  wire logic                    i_s_axi_wvalid,
    output logic                         o_s_axi_wready,
    output var rx_param_pkg::axi_resp_e  o_s_axi_bresp,
    output logic                         o_s_axi_bvalid,
    input  wire logic                    i_s_axi_bready,
    input  wire logic [ADDR_W-1:0]       i_s_axi_araddr,
    input  wire logic                    i_s_axi_arvalid,
    output logic                         o_s_axi_arready,
    output logic      [31:0]             o_s_axi_rdata,
    output var rx_param_pkg::axi_resp_e  o_s_axi_rresp,
    output logic                         o_s_axi_rvalid,
    input  wire logic                    i_s_axi_rready,
    output logic                         o_params_valid
);
    import rx_param_pkg::*;

    localparam int NREG = `RLPC_NUM_REGS;
    localparam logic [NREG*8-1:0] MASKS = {
        `RLPC_MASK_SUBCLASS, `RLPC_MASK_CTRL_RES, `RLPC_MASK_CONVERTERS,
        `RLPC_MASK_FRAMES, `RLPC_MASK_OCTETS, `RLPC_MASK_SCR_LANES,
        `RLPC_MASK_LANE_ID
    };

    logic                 cfg_load;
    logic [NREG*8-1:0]    cfg_bytes;
    logic [7:0]           field_q [NREG];
    logic [NREG*8-1:0]    fields_flat;

    logic                 aw_fire;
    logic                 w_fire;
    logic                 b_fire;
    logic                 ar_fire;
    logic                 r_fire;
    logic                 aw_hold_r;
    logic                 w_hold_r;
    logic [ADDR_W-1:0]    wr_addr_r;

    // Mapped when word aligned and inside the seven-register window
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-3:0] w;
        w = a[ADDR_W-1:2];
        return (a[1:0] == 2'b00) && (w >= `RLPC_IDX_LANE_ID) &&
               (w <= `RLPC_IDX_SUBCLASS);
    endfunction

    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-3:0] w;
        w = a[ADDR_W-1:2] - `RLPC_IDX_LANE_ID;
        return w[2:0];
    endfunction

    // Parameter octets from lane 0, checksum verified
    ila_cfg_parser #(
        .CAP_NUM (NREG)
    ) u_parser (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_start   (i_ila_start),
        .i_valid   (i_ila_valid),
        .i_octet   (i_ila_octet),
        .o_load    (cfg_load),
        .o_bytes   (cfg_bytes)
    );

    // Each register holds one captured octet, reserved bits forced low
    for (genvar g = 0; g < NREG; g++)
    begin : g_field
        ro_field_reg #(
            .MASK (MASKS[g*8 +: 8])
        ) u_field (
            .i_clk_sys (i_clk_sys),
            .i_rstn    (i_rstn),
            .i_load    (cfg_load),
            .i_data    (cfg_bytes[g*8 +: 8]),
            .o_value   (field_q[g])
        );
        assign fields_flat[g*8 +: 8] = field_q[g];
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            o_params_valid <= 1'b0;
        else if (cfg_load)
            o_params_valid <= 1'b1;
    end

    assign aw_fire = i_s_axi_awvalid & o_s_axi_awready;
    assign w_fire  = i_s_axi_wvalid & o_s_axi_wready;
    assign b_fire  = o_s_axi_bvalid & i_s_axi_bready;
    assign ar_fire = i_s_axi_arvalid & o_s_axi_arready;
    assign r_fire  = o_s_axi_rvalid & i_s_axi_rready;

    // Write address: held until the response is taken
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            aw_hold_r       <= 1'b0;
            wr_addr_r       <= '0;
            o_s_axi_awready <= 1'b0;
        end
        else
        begin
            if (aw_fire)
            begin
                aw_hold_r <= 1'b1;
                wr_addr_r <= i_s_axi_awaddr;
            end
            else if (b_fire)
                aw_hold_r <= 1'b0;
            o_s_axi_awready <= b_fire | (~aw_hold_r & ~aw_fire);
        end
    end

    // Write data is accepted and dropped: every register is read-only
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            w_hold_r       <= 1'b0;
            o_s_axi_wready <= 1'b0;
        end
        else
        begin
            if (w_fire)
                w_hold_r <= 1'b1;
            else if (b_fire)
                w_hold_r <= 1'b0;
            o_s_axi_wready <= b_fire | (~w_hold_r & ~w_fire);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= RESP_OKAY;
        end
        else if (b_fire)
            o_s_axi_bvalid <= 1'b0;
        else if (aw_hold_r && w_hold_r && !o_s_axi_bvalid)
        begin
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp  <= addr_hit(wr_addr_r) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Read: one cycle from address to data
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            o_s_axi_arready <= 1'b0;
        else
            o_s_axi_arready <= r_fire | (~o_s_axi_rvalid & ~ar_fire);
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata  <= 32'h0;
            o_s_axi_rresp  <= RESP_OKAY;
        end
        else if (ar_fire)
        begin
            o_s_axi_rvalid <= 1'b1;
            if (addr_hit(i_s_axi_araddr))
            begin
                o_s_axi_rdata <= {24'h0, field_q[reg_sel(i_s_axi_araddr)]};
                o_s_axi_rresp <= RESP_OKAY;
            end
            else
            begin
                o_s_axi_rdata <= 32'h0;
                o_s_axi_rresp <= RESP_SLVERR;
            end
        end
        else if (r_fire)
            o_s_axi_rvalid <= 1'b0;
    end

    // Checks
    logic [2:0] chk_sel_r;
    logic       chk_hit_r;

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            chk_sel_r <= 3'h0;
            chk_hit_r <= 1'b0;
        end
        else if (ar_fire)
        begin
            chk_sel_r <= reg_sel(i_s_axi_araddr);
            chk_hit_r <= addr_hit(i_s_axi_araddr);
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    sequence s_read_req;
        ar_fire;
    endsequence

    sequence s_read_answer;
        o_s_axi_rvalid && !o_s_axi_arready;
    endsequence

    sequence s_write_both;
        aw_hold_r && w_hold_r && !o_s_axi_bvalid;
    endsequence

    a_read_latency: assert property (s_read_req |=> s_read_answer)
        else $error("read answer not one cycle after address");

    a_read_field: assert property (
        o_s_axi_rvalid && $rose(o_s_axi_rvalid) && chk_hit_r |->
        o_s_axi_rdata == {24'h0, field_q[chk_sel_r]})
        else $error("read data does not match captured field");

    a_lane_id_capture: assert property (
        cfg_load |=> field_q[0][4:0] == $past(cfg_bytes[4:0]))
        else $error("lane identifier not captured");

    a_adj_direction: assert property (
        cfg_load |=> field_q[0][6] == $past(cfg_bytes[6]) &&
        field_q[0][7] == 1'b0)
        else $error("adjust direction flag wrong");

    a_phase_request: assert property (
        cfg_load |=> field_q[0][5] == $past(cfg_bytes[5]))
        else $error("phase adjust flag wrong");

    a_scramble_flag: assert property (
        cfg_load |=> field_q[1][7] == $past(cfg_bytes[15]) &&
        field_q[1][6:5] == 2'h0)
        else $error("scrambling flag wrong");

    a_lane_count: assert property (
        cfg_load |=> field_q[1][4:0] == $past(cfg_bytes[12:8]))
        else $error("lane count wrong");

    a_octets_frame: assert property (
        cfg_load |=> field_q[2] == $past(cfg_bytes[23:16]))
        else $error("octets per frame wrong");

    a_frames_multi: assert property (
        cfg_load |=> field_q[3] == {3'h0, $past(cfg_bytes[28:24])})
        else $error("frames per multiframe wrong");

    a_converter_count: assert property (
        cfg_load |=> field_q[4] == $past(cfg_bytes[39:32]))
        else $error("converter count wrong");

    a_control_bits: assert property (
        cfg_load |=> field_q[5][7:6] == $past(cfg_bytes[47:46]) &&
        field_q[5][5] == 1'b0)
        else $error("control bits field wrong");

    a_subclass_field: assert property (
        cfg_load |=> field_q[6][7:5] == $past(cfg_bytes[55:53]))
        else $error("subclass version wrong");

    a_fields_hold: assert property (
        !cfg_load |=> $stable(fields_flat))
        else $error("fields changed without a capture");

    a_zero_until_valid: assert property (
        !o_params_valid |-> fields_flat == '0)
        else $error("fields nonzero before first capture");

    a_write_response: assert property (
        s_write_both |=> o_s_axi_bvalid ##0
        (o_s_axi_bresp == RESP_OKAY) == addr_hit(wr_addr_r))
        else $error("write response missing or wrong");

    // Next request may be offered once the response is taken
    a_read_reopen: assert property (r_fire |=> o_s_axi_arready)
        else $error("read address not reopened after response");

    a_write_reopen: assert property (
        b_fire |=> o_s_axi_awready && o_s_axi_wready)
        else $error("write channels not reopened after response");

    a_valid_sticky: assert property (
        o_params_valid |=> o_params_valid)
        else $error("parameter valid flag dropped without reset");
endmodule
`default_nettype wire

// ===== test/ila_sender.sv
// Lane 0 transmitter model: sends one 14-octet configuration set.
// Assumes the bench calls send() from its main sequence on i_clk_sys.
`default_nettype none
module ila_sender (
    input  wire logic       i_clk_sys,
    output logic            o_start,
    output logic            o_valid,
    output logic      [7:0] o_octet
);
    timeunit 1ns;
    timeprecision 1ps;

    logic busy = 1'b0;

    initial
    begin
        o_start = 1'b0;
        o_valid = 1'b0;
        o_octet = 8'h00;
    end

    // A released data line flips every idle cycle
    always @(posedge i_clk_sys)
    begin
        if (!busy)
            o_octet <= ~o_octet;
    end

    // Mode 0 good set, 1 bad checksum, 2 start flag withheld
    task automatic send(input logic [55:0] p, input int mode,
                        input logic gap);
        logic [7:0] oct [14];
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 0; i < 14; i++)
            oct[i] = (i >= 2 && i <= 8) ? p[(i-2)*8 +: 8] : 8'h00;
        for (int i = 0; i < 13; i++)
            sum = sum + oct[i];
        oct[13] = (mode == 1) ? ~sum : sum;
        @(posedge i_clk_sys);
        busy <= 1'b1;
        for (int i = 0; i < 14; i++)
        begin
            if (gap && i == 6)
            begin
                @(posedge i_clk_sys);
                o_valid <= 1'b0;
                o_start <= 1'b0;
                o_octet <= ~oct[i-1];
            end
            @(posedge i_clk_sys);
            o_start <= (i == 0 && mode != 2);
            o_valid <= 1'b1;
            o_octet <= oct[i];
        end
        @(posedge i_clk_sys);
        o_start <= 1'b0;
        o_valid <= 1'b0;
        busy    <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== test/rx_link_param_capture_bench.sv
// Bench for the lane 0 parameter bank: AXI4-Lite master tasks, checks.
// Assumes ila_sender drives the lane 0 octet stream.
`default_nettype none
`include "rx_link_param_regs.svh"
module rx_link_param_capture_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rx_param_pkg::*;

    logic        clk, rstn, ila_start, ila_valid, params_valid;
    logic [7:0]  ila_octet;
    logic [12:0] awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    axi_resp_e   bresp, rresp, r;
    int          fails, n_tests;

    localparam logic [55:0] field_masks = {`RLPC_MASK_SUBCLASS,
        `RLPC_MASK_CTRL_RES, `RLPC_MASK_CONVERTERS, `RLPC_MASK_FRAMES,
        `RLPC_MASK_OCTETS, `RLPC_MASK_SCR_LANES, `RLPC_MASK_LANE_ID};
    // Legal F, K, M and zero control bits only; first two sets have reserved
    // bits raised
    localparam logic [55:0] sets [3] = '{56'h2f2f01ef01e1c5,
        56'h2f0f03ff03033f, 56'h0d0d000f008040};

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ila_sender ila_sender_inst (.i_clk_sys(clk), .o_start(ila_start),
        .o_valid(ila_valid), .o_octet(ila_octet));

    rx_link_param_capture #(.ADDR_W(13)) rx_link_param_capture_inst (
        .i_clk_sys(clk), .i_rstn(rstn), .i_ila_start(ila_start),
        .i_ila_valid(ila_valid), .i_ila_octet(ila_octet),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(rready), .o_params_valid(params_valid));

    task automatic print_verdict;
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Wait limit: a hang counts as a mismatch and ends the run
    task automatic guard(inout int n);
        n++;
        if (n > 200)
        begin
            fails++;
            print_verdict();
        end
    endtask

    task automatic axi_read(input logic [12:0] a, output logic [31:0] dv,
                            output axi_resp_e rv);
        int n;
        n = 0;
        @(posedge clk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        @(negedge clk);
        while (arready !== 1'b1)
        begin
            guard(n);
            @(negedge clk);
        end
        @(posedge clk);
        arvalid <= 1'b0;
        @(negedge clk);
        while (rvalid !== 1'b1)
        begin
            guard(n);
            @(negedge clk);
        end
        dv = rdata;
        rv = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask

    task automatic axi_write(input logic [12:0] a, output axi_resp_e rv);
        int   n;
        logic aw_done, w_done, ta, tw;
        n = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= 32'hffffffff;
        wvalid  <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(negedge clk);
            guard(n);
            ta = !aw_done && awready === 1'b1;
            tw = !w_done && wready === 1'b1;
            @(posedge clk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
            aw_done = aw_done | ta;
            w_done = w_done | tw;
        end
        bready <= 1'b1;
        @(negedge clk);
        while (bvalid !== 1'b1)
        begin
            guard(n);
            @(negedge clk);
        end
        rv = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask

    task automatic read_all(input logic [55:0] exp);
        logic [31:0] dv;
        axi_resp_e   rv;
        for (int i = 0; i < 7; i++)
        begin
            axi_read(13'h1008 + 13'(4 * i), dv, rv);
            check($sformatf("reg %0d", i), dv,
                  {24'h0, exp[i*8 +: 8]});
            check("rresp", 32'(rv), 32'(RESP_OKAY));
        end
    endtask

    initial
    begin
        fails = 0;
        n_tests = 0;
        rstn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 13'h0000;
        araddr = 13'h0000;
        wdata = 32'h00000000;
        wstrb = 4'hf;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        read_all(56'h0);
        check("params_valid", 32'(params_valid), 32'h0);
        for (int s = 0; s < 3; s++)
        begin
            ila_sender_inst.send(sets[s], 0, s == 1);
            read_all(sets[s] & field_masks);
            check("params_valid", 32'(params_valid), 32'h1);
            if (s == 0)
            begin
                axi_write(13'h1008, r);
                check("bresp", 32'(r), 32'(RESP_OKAY));
                axi_write(13'h1000, r);
                check("bresp", 32'(r), 32'(RESP_SLVERR));
                axi_read(13'h1000, d, r);
                check("rdata", d, 32'h0);
                check("rresp", 32'(r), 32'(RESP_SLVERR));
                axi_read(13'h100a, d, r);
                check("rresp", 32'(r), 32'(RESP_SLVERR));
                read_all(sets[0] & field_masks);
            end
        end
        ila_sender_inst.send(sets[0], 1, 1'b0);
        read_all(sets[2] & field_masks);
        ila_sender_inst.send(sets[0], 2, 1'b1);
        read_all(sets[2] & field_masks);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        read_all(56'h0);
        check("params_valid", 32'(params_valid), 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
